// ===== boot_loader_consts.vh
// Purpose: Shared constants of the boot program loader.
// Assumes: Included by bare name; definitions only.
// Notes:   Switch bit n is data_switches[n].
`ifndef BOOT_LOADER_CONSTS_VH
`define BOOT_LOADER_CONSTS_VH

// Bootstrap store and its target
`define ROM_LAST_IDX      6'h3F
`define BOOT_BASE_HI      10'h000
`define GR_FIFTEEN        4'hF

// Register byte offsets
`define OFF_CTRL          4'h0
`define OFF_STATUS        4'h4
`define OFF_SWITCH        4'h8
`define OFF_DECODE        4'hC

// Control and status fields
`define CTRL_START        0
`define CTRL_ENABLE       1
`define CTRL_ENABLE_RST   1'b1
`define ST_BUSY           0
`define ST_DONE           1
`define ST_FITTED         2

// Data switch fields
`define SW_TELEPRINTER    0
`define SW_DISC           1
`define SW_FORMAT_OPT     2
`define SW_PROG_CHANNEL   3
`define SW_CU_LSB         4
`define SW_CU_MSB         7
`define SW_MULTI_DEVICE   8
`define SW_DISC_USED      9
`define SW_ADDR_LSB       10
`define SW_ADDR_MSB       15

// Control-unit type codes
`define CU_TELETYPE       4'h1
`define CU_MAG_TAPE       4'h2
`define CU_DISC           4'h3
`define CU_TAPE_KEYBOARD  4'h7

// AXI responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ===== boot_rom.v
// Purpose: Sixty-four word read-only bootstrap store.
// Assumes: Image supplied as a parameter at build time.
// Notes:   Combinational read; the caller registers the word.
`timescale 1ns/10ps
module boot_rom #(
   parameter [1023:0] IMAGE = 1024'h0
) (
   input  wire [5:0]  word_sel,
   output wire [15:0] word
);
   // The image holds binary machine code only; its sole check is a checksum
   assign word = IMAGE[{word_sel, 4'h0} +: 16];
endmodule // boot_rom

// ===== axil_regs.v
// Purpose: AXI4-Lite register slave of the boot program loader.
// Assumes: One write and one read outstanding at a time.
// Notes:   Address and data may arrive in either order.
`timescale 1ns/10ps
`include "boot_loader_consts.vh"
module axil_regs (
   input  wire        clock,
   input  wire        rst,
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire [31:0] status_word,
   input  wire [31:0] switch_word,
   input  wire [31:0] decode_word,
   input  wire        done_set,
   output reg         sw_start_q,
   output reg         panel_enable_q,
   output reg         done_q
);
   reg [3:0]  aw_addr_q;
   reg [31:0] w_data_q;
   reg [3:0]  w_strb_q;
   reg        aw_got_q;
   reg        w_got_q;
   wire       do_write = aw_got_q & w_got_q & ~s_axi_bvalid;
   wire       wr_ctrl  = do_write & (aw_addr_q == `OFF_CTRL) & w_strb_q[0];
   wire       wr_stat  = do_write & (aw_addr_q == `OFF_STATUS) & w_strb_q[0];
   wire       wr_known = (aw_addr_q == `OFF_CTRL) | (aw_addr_q == `OFF_STATUS) |
                         (aw_addr_q == `OFF_SWITCH) | (aw_addr_q == `OFF_DECODE);

   always @(posedge clock) begin
      if (rst) begin
         s_axi_awready  <= 1'b1;
         s_axi_wready   <= 1'b1;
         s_axi_bvalid   <= 1'b0;
         s_axi_bresp    <= `RESP_OKAY;
         aw_got_q       <= 1'b0;
         w_got_q        <= 1'b0;
         aw_addr_q      <= 4'h0;
         w_data_q       <= 32'h00000000;
         w_strb_q       <= 4'h0;
         sw_start_q     <= 1'b0;
         panel_enable_q <= `CTRL_ENABLE_RST;
         done_q         <= 1'b0;
      end else begin
         sw_start_q <= 1'b0;
         if (s_axi_awready & s_axi_awvalid) begin
            aw_addr_q     <= {s_axi_awaddr[3:2], 2'h0};
            aw_got_q      <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wready & s_axi_wvalid) begin
            w_data_q     <= s_axi_wdata;
            w_strb_q     <= s_axi_wstrb;
            w_got_q      <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
         if (wr_ctrl) begin
            sw_start_q     <= w_data_q[`CTRL_START];
            panel_enable_q <= w_data_q[`CTRL_ENABLE];
         end
         // A completion in the clearing cycle is kept
         done_q <= done_set | (done_q & ~(wr_stat & w_data_q[`ST_DONE]));
      end
   end

   always @(posedge clock) begin
      if (rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `RESP_OKAY;
      end else if (s_axi_arready & s_axi_arvalid) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= `RESP_OKAY;
         case ({s_axi_araddr[3:2], 2'h0})
            `OFF_CTRL:   s_axi_rdata <= {30'h0, panel_enable_q, 1'b0};
            `OFF_STATUS: s_axi_rdata <= status_word;
            `OFF_SWITCH: s_axi_rdata <= switch_word;
            `OFF_DECODE: s_axi_rdata <= decode_word;
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule // axil_regs

// ===== boot_program_loader.v
// Purpose: Loads the bootstrap into low memory and starts the CPU.
// Assumes: Memory and CPU ports answer on this clock with one-cycle acks.
// Notes:   Panel pins are synchronised; CPU is held while loading.
// Operation
// - Button loads and starts only when option fitted
// - Sixty-four word bootstrap store plus control
// - Bootstrap holds binary code, checksum only
// - Switch 2 ignored when switch 0 clear
// - Copy whole bootstrap into memory words 0-63
// - Copy data switches into general register fifteen
// - Inhibit interrupts before bootstrap runs
// - Clear program counter, then start run mode
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "boot_loader_consts.vh"
module boot_program_loader #(
   parameter [1023:0] BOOT_IMAGE = 1024'h0
) (
   input  wire        clock,
   input  wire        rst,
   input  wire        option_fitted,
   input  wire        load_button,
   input  wire [15:0] data_switches,
   output reg         mem_wr_req,
   output reg  [15:0] mem_wr_addr,
   output reg  [15:0] mem_wr_data,
   input  wire        mem_wr_ack,
   output reg         gr_wr_req,
   output reg  [3:0]  gr_wr_sel,
   output reg  [15:0] gr_wr_data,
   input  wire        gr_wr_ack,
   output reg         cpu_hold,
   output reg         int_inhibit_set,
   output reg         pc_clear,
   output reg         cpu_run_start,
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready
);
   localparam [2:0] S_IDLE     = 3'h0;
   localparam [2:0] S_COPY_SET = 3'h1;
   localparam [2:0] S_COPY_ACK = 3'h2;
   localparam [2:0] S_GR_ACK   = 3'h3;
   localparam [2:0] S_INHIBIT  = 3'h4;
   localparam [2:0] S_PC_CLEAR = 3'h5;
   localparam [2:0] S_RUN      = 3'h6;

   // Two-flop synchronisers; only the second stage is read
   reg  [17:0] pins_s1_q;
   reg  [17:0] pins_s2_q;
   reg         button_prev_q;
   reg  [2:0]  state_q;
   reg  [5:0]  word_idx_q;
   reg  [15:0] switches_q;
   reg         done_pulse_q;
   wire [15:0] rom_word;
   wire        sw_start;
   wire        panel_enable;
   wire        done_flag;

   wire [15:0] sw_live      = pins_s2_q[15:0];
   wire        button_live  = pins_s2_q[16];
   wire        fitted_live  = pins_s2_q[17];
   wire        button_press = button_live & ~button_prev_q;
   // Without the option fitted, neither the button nor software starts a load
   wire        start = fitted_live & panel_enable & (state_q == S_IDLE) & (button_press | sw_start);

   always @(posedge clock) begin
      if (rst) begin
         pins_s1_q     <= 18'h00000;
         pins_s2_q     <= 18'h00000;
         button_prev_q <= 1'b0;
      end else begin
         pins_s1_q     <= {option_fitted, load_button, data_switches};
         pins_s2_q     <= pins_s1_q;
         button_prev_q <= button_live;
      end
   end

   boot_rom #(
      .IMAGE (BOOT_IMAGE)
   ) u_rom (
      .word_sel (word_idx_q),
      .word     (rom_word)
   );

   always @(posedge clock) begin
      if (rst) begin
         state_q         <= S_IDLE;
         word_idx_q      <= 6'h00;
         switches_q      <= 16'h0000;
         mem_wr_req      <= 1'b0;
         mem_wr_addr     <= 16'h0000;
         mem_wr_data     <= 16'h0000;
         gr_wr_req       <= 1'b0;
         gr_wr_sel       <= 4'h0;
         gr_wr_data      <= 16'h0000;
         cpu_hold        <= 1'b0;
         int_inhibit_set <= 1'b0;
         pc_clear        <= 1'b0;
         cpu_run_start   <= 1'b0;
         done_pulse_q    <= 1'b0;
      end else begin
         int_inhibit_set <= 1'b0;
         pc_clear        <= 1'b0;
         cpu_run_start   <= 1'b0;
         done_pulse_q    <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (start) begin
                  // Switches are frozen so the whole load sees one setting
                  switches_q <= sw_live;
                  word_idx_q <= 6'h00;
                  cpu_hold   <= 1'b1;
                  state_q    <= S_COPY_SET;
               end
            end
            S_COPY_SET: begin
               mem_wr_req  <= 1'b1;
               mem_wr_addr <= {`BOOT_BASE_HI, word_idx_q};
               mem_wr_data <= rom_word;
               state_q     <= S_COPY_ACK;
            end
            S_COPY_ACK: begin
               // Each word waits for its ack before the next goes out
               if (mem_wr_ack) begin
                  mem_wr_req <= 1'b0;
                  if (word_idx_q == `ROM_LAST_IDX) begin
                     gr_wr_req  <= 1'b1;
                     gr_wr_sel  <= `GR_FIFTEEN;
                     gr_wr_data <= switches_q;
                     state_q    <= S_GR_ACK;
                  end else begin
                     word_idx_q <= word_idx_q + 6'h01;
                     state_q    <= S_COPY_SET;
                  end
               end
            end
            S_GR_ACK: begin
               if (gr_wr_ack) begin
                  gr_wr_req       <= 1'b0;
                  int_inhibit_set <= 1'b1;
                  state_q         <= S_INHIBIT;
               end
            end
            S_INHIBIT: begin
               pc_clear <= 1'b1;
               state_q  <= S_PC_CLEAR;
            end
            S_PC_CLEAR: begin
               // Hold drops with the run pulse so nothing runs before the clear
               cpu_run_start <= 1'b1;
               cpu_hold      <= 1'b0;
               done_pulse_q  <= 1'b1;
               state_q       <= S_RUN;
            end
            S_RUN: begin
               state_q <= S_IDLE;
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   // Decoded view of the frozen switches; the bootstrap reads the raw word
   wire [3:0] cu_type     = switches_q[`SW_CU_MSB:`SW_CU_LSB];
   wire       src_reader  = switches_q[`SW_TELEPRINTER];
   wire       src_disc    = switches_q[`SW_DISC];
   wire       fmt_opt     = switches_q[`SW_TELEPRINTER] & switches_q[`SW_FORMAT_OPT];
   wire       prog_chan   = switches_q[`SW_PROG_CHANNEL];
   wire       multi_dev   = switches_q[`SW_MULTI_DEVICE];
   wire       disc_used   = switches_q[`SW_DISC_USED];
   wire [5:0] dev_addr    = switches_q[`SW_ADDR_MSB:`SW_ADDR_LSB];
   wire       src_other   = ~src_reader & ~src_disc;
   wire       cu_known    = (cu_type == `CU_TELETYPE) | (cu_type == `CU_MAG_TAPE) |
                            (cu_type == `CU_DISC) | (cu_type == `CU_TAPE_KEYBOARD);

   wire [31:0] status_word = {10'h000, word_idx_q, 5'h00, state_q, 5'h00,
                              fitted_live, done_flag, cpu_hold};
   wire [31:0] decode_word = {14'h0000, dev_addr, cu_type, cu_known, disc_used, multi_dev,
                              prog_chan, fmt_opt, src_other, src_disc, src_reader};

   axil_regs u_regs (
      .clock          (clock),
      .rst            (rst),
      .s_axi_awaddr   (s_axi_awaddr),
      .s_axi_awvalid  (s_axi_awvalid),
      .s_axi_awready  (s_axi_awready),
      .s_axi_wdata    (s_axi_wdata),
      .s_axi_wstrb    (s_axi_wstrb),
      .s_axi_wvalid   (s_axi_wvalid),
      .s_axi_wready   (s_axi_wready),
      .s_axi_bresp    (s_axi_bresp),
      .s_axi_bvalid   (s_axi_bvalid),
      .s_axi_bready   (s_axi_bready),
      .s_axi_araddr   (s_axi_araddr),
      .s_axi_arvalid  (s_axi_arvalid),
      .s_axi_arready  (s_axi_arready),
      .s_axi_rdata    (s_axi_rdata),
      .s_axi_rresp    (s_axi_rresp),
      .s_axi_rvalid   (s_axi_rvalid),
      .s_axi_rready   (s_axi_rready),
      .status_word    (status_word),
      .switch_word    ({16'h0000, switches_q}),
      .decode_word    (decode_word),
      .done_set       (done_pulse_q),
      .sw_start_q     (sw_start),
      .panel_enable_q (panel_enable),
      .done_q         (done_flag)
   );
endmodule // boot_program_loader

// ===== boot_program_loader_asserts.sv
// Purpose: Port-level timing checks of the boot program loader.
// Assumes: Bound to every boot_program_loader instance.
// Notes:   Acks come from the far side; only design outputs are judged.
`timescale 1ns/10ps
module boot_loader_checker (
   input wire        clock,
   input wire        rst,
   input wire        mem_wr_req,
   input wire [15:0] mem_wr_addr,
   input wire [15:0] mem_wr_data,
   input wire        mem_wr_ack,
   input wire        gr_wr_req,
   input wire [3:0]  gr_wr_sel,
   input wire        gr_wr_ack,
   input wire        cpu_hold,
   input wire        int_inhibit_set,
   input wire        pc_clear,
   input wire        cpu_run_start
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   chk_first_word: assert property ($rose(cpu_hold) |=> mem_wr_req && mem_wr_addr == 16'h0000)
      else $error("copy does not open at word zero");
   chk_addr_range: assert property (mem_wr_req |-> mem_wr_addr <= 16'h003F)
      else $error("copy address beyond bootstrap");
   chk_req_holds: assert property (mem_wr_req && !mem_wr_ack |=> mem_wr_req && $stable(mem_wr_addr) && $stable(mem_wr_data))
      else $error("memory write changed before ack");
   chk_ack_drops: assert property (mem_wr_ack |=> !mem_wr_req)
      else $error("memory request kept after ack");
   chk_gr_after_copy: assert property (mem_wr_ack && mem_wr_addr == 16'h003F |-> ##[1:3] gr_wr_req)
      else $error("register write missing after copy");
   chk_gr_sel: assert property (gr_wr_req |-> gr_wr_sel == 4'hF && !mem_wr_req)
      else $error("register write not to register fifteen");
   chk_inhibit_next: assert property (gr_wr_ack |=> !gr_wr_req && int_inhibit_set)
      else $error("interrupt inhibit not after register write");
   chk_pc_order: assert property (int_inhibit_set |=> pc_clear ##1 (cpu_run_start && !cpu_hold))
      else $error("counter clear and run out of order");
   chk_hold_load: assert property (mem_wr_req || gr_wr_req || int_inhibit_set || pc_clear |-> cpu_hold)
      else $error("cpu released during load");
endmodule // boot_loader_checker

bind boot_program_loader boot_loader_checker boot_loader_checker_i (.clock, .rst, .mem_wr_req, .mem_wr_addr,
   .mem_wr_data, .mem_wr_ack, .gr_wr_req, .gr_wr_sel, .gr_wr_ack, .cpu_hold, .int_inhibit_set, .pc_clear,
   .cpu_run_start);

// ===== mem_cpu_model.sv
// Purpose: Central memory and CPU seen from the loader.
// Assumes: One request at a time; ack after delay idle cycles.
// Notes:   Records order of events so a reordered load shows.
`timescale 1ns/10ps
module mem_cpu_model (
   input  wire        clock,
   input  wire        clear,
   input  wire [3:0]  delay,
   input  wire        mem_wr_req,
   input  wire [15:0] mem_wr_addr,
   input  wire [15:0] mem_wr_data,
   output reg         mem_wr_ack,
   input  wire        gr_wr_req,
   input  wire [15:0] gr_wr_data,
   output reg         gr_wr_ack,
   input  wire        int_inhibit_set,
   input  wire        pc_clear,
   input  wire        cpu_run_start
);
   reg [15:0] mem [0:63];
   reg [15:0] gr15;
   reg [6:0]  wr_count;
   reg [2:0]  seq;
   reg        order_err;
   reg [3:0]  cnt;
   wire       go = (mem_wr_req | gr_wr_req) && !(mem_wr_ack | gr_wr_ack) && cnt == delay;
   always @(posedge clock) begin
      mem_wr_ack <= go & mem_wr_req;
      gr_wr_ack  <= go & gr_wr_req;
      // The register write follows the last ack with no idle gap, so the ack restarts the count
      cnt        <= (!(mem_wr_req | gr_wr_req) || go || mem_wr_ack || gr_wr_ack) ? 4'h0 : cnt + 4'h1;
      if (clear) begin
         wr_count  <= 7'h00;
         seq       <= 3'h0;
         order_err <= 1'b0;
         gr15      <= 16'h0000;
      end else begin
         if (mem_wr_ack) begin
            mem[mem_wr_addr[5:0]] <= mem_wr_data;
            wr_count <= wr_count + 7'h01;
            if (mem_wr_addr != {9'h000, wr_count} || seq != 3'h0)
               order_err <= 1'b1;
         end
         // Each step only counts once the previous one has landed
         if (gr_wr_ack && wr_count == 7'h40) begin
            gr15 <= gr_wr_data;
            seq  <= 3'h1;
         end
         if (int_inhibit_set) seq <= (seq == 3'h1) ? 3'h2 : 3'h7;
         if (pc_clear) seq <= (seq == 3'h2) ? 3'h3 : 3'h7;
         if (cpu_run_start) seq <= (seq == 3'h3) ? 3'h4 : 3'h7;
      end
   end
endmodule // mem_cpu_model

// ===== test_boot_program_loader.sv
// Purpose: Self-checking bench of the boot program loader.
// Assumes: Registers reached over AXI4-Lite; far side is mem_cpu_model.
// Notes:   Each load is started by panel or register, then judged.
`timescale 1ns/10ps
`define CHECK(a, b) begin compares = compares + 1; if ((a) !== (b)) begin fail_count = fail_count + 1; \
   $display("[ERR] %0t mismatch got %h want %h", $time, (a), (b)); end end
module test_boot_program_loader;
   localparam [1023:0] IMG = {16{64'h0123456789ABCDEF}};
   reg         clock = 1'b0, rst = 1'b1, option_fitted = 1'b1, load_button = 1'b0, clear = 1'b1;
   reg  [15:0] data_switches = 16'h0000;
   reg  [3:0]  delay = 4'h0, awaddr = 4'h0, araddr = 4'h0;
   reg  [31:0] wdata = 32'h0, rd;
   reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire [15:0] mem_wr_addr, mem_wr_data, gr_wr_data;
   wire [3:0]  gr_wr_sel;
   wire [31:0] rdata;
   wire [1:0]  bresp, rresp;
   wire        mem_wr_req, mem_wr_ack, gr_wr_req, gr_wr_ack, cpu_hold, int_inhibit_set, pc_clear, cpu_run_start;
   wire        awready, wready, bvalid, arready, rvalid;
   integer     fail_count = 0, compares = 0, cycles = 0, i;
   boot_program_loader #(.BOOT_IMAGE(IMG)) boot_program_loader_i (.clock(clock), .rst(rst),
      .option_fitted(option_fitted), .load_button(load_button), .data_switches(data_switches),
      .mem_wr_req(mem_wr_req), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .mem_wr_ack(mem_wr_ack),
      .gr_wr_req(gr_wr_req), .gr_wr_sel(gr_wr_sel), .gr_wr_data(gr_wr_data), .gr_wr_ack(gr_wr_ack),
      .cpu_hold(cpu_hold), .int_inhibit_set(int_inhibit_set), .pc_clear(pc_clear), .cpu_run_start(cpu_run_start),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   mem_cpu_model mem_cpu_model_i (.clock(clock), .clear(clear), .delay(delay), .mem_wr_req(mem_wr_req),
      .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .mem_wr_ack(mem_wr_ack), .gr_wr_req(gr_wr_req),
      .gr_wr_data(gr_wr_data), .gr_wr_ack(gr_wr_ack), .int_inhibit_set(int_inhibit_set), .pc_clear(pc_clear),
      .cpu_run_start(cpu_run_start));
   always #20 clock = ~clock;
   always @(posedge clock) begin
      cycles = cycles + 1;
      if (cycles == 30000) begin
         fail_count = fail_count + 1;
         print_verdict;
      end
   end
   task print_verdict;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task axi_write(input [3:0] a, input [31:0] d);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do begin
         @(posedge clock);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      `CHECK(bresp, 2'h0)
      bready <= 1'b0;
      // One edge passes so a following call never re-raises bready in the same step
      @(posedge clock);
   endtask
   task axi_read(input [3:0] a);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(posedge clock);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      `CHECK(rresp, 2'h0)
      rready <= 1'b0;
      @(posedge clock);
   endtask
   task press_button;
      load_button <= 1'b1;
      repeat (4) @(posedge clock);
      load_button <= 1'b0;
      repeat (4) @(posedge clock);
   endtask
   task t_reset_values;
      axi_read(4'h0);
      `CHECK(rd[1:0], 2'h2)
      axi_read(4'h4);
      `CHECK(rd[2:0], 3'h4)
      $display("t_reset_values done");
   endtask
   // Loads one switch setting; a second start while busy must be ignored
   task t_load(input [15:0] sw, input [3:0] dl, input by_button);
      data_switches <= sw; delay <= dl; clear <= 1'b1;
      repeat (4) @(posedge clock);
      clear <= 1'b0;
      if (by_button) press_button; else axi_write(4'h0, 32'h3);
      repeat (10) @(posedge clock);
      axi_write(4'h0, 32'h3);
      while (cpu_run_start !== 1'b1) @(posedge clock);
      repeat (3) @(posedge clock);
      `CHECK(mem_cpu_model_i.wr_count, 7'h40)
      `CHECK(mem_cpu_model_i.order_err, 1'b0)
      `CHECK(mem_cpu_model_i.seq, 3'h4)
      `CHECK(mem_cpu_model_i.gr15, sw)
      for (i = 0; i < 64; i = i + 1)
         `CHECK(mem_cpu_model_i.mem[i], IMG[16*i +: 16])
      axi_read(4'h4);
      `CHECK(rd[1:0], 2'h2)
      axi_read(4'h8);
      `CHECK(rd[15:0], sw)
      axi_read(4'hC);
      `CHECK(rd[17:0], {sw[15:10], sw[7:4], (sw[7:4] == 4'h1) | (sw[7:4] == 4'h2) | (sw[7:4] == 4'h3) |
         (sw[7:4] == 4'h7), sw[9], sw[8], sw[3], sw[2] & sw[0], ~(sw[0] | sw[1]),
         sw[1], sw[0]})
      axi_write(4'h4, 32'h2);
      axi_read(4'h4);
      `CHECK(rd[1], 1'b0)
      $display("t_load %h done", sw);
   endtask
   task t_refused;
      clear <= 1'b1; option_fitted <= 1'b0;
      repeat (4) @(posedge clock);
      clear <= 1'b0;
      press_button;
      axi_write(4'h0, 32'h3);
      repeat (6) @(posedge clock);
      `CHECK(cpu_hold, 1'b0)
      option_fitted <= 1'b1;
      axi_write(4'h0, 32'h0);
      repeat (4) @(posedge clock);
      press_button;
      repeat (6) @(posedge clock);
      `CHECK(cpu_hold, 1'b0)
      `CHECK(mem_cpu_model_i.wr_count, 7'h00)
      axi_write(4'h0, 32'h2);
      $display("t_refused done");
   endtask
   initial begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      repeat (3) @(posedge clock);
      t_reset_values;
      t_load(16'h041D, 4'h0, 1'b1);
      t_load(16'h2920, 4'h3, 1'b0);
      t_load(16'hFE3A, 4'h1, 1'b0);
      t_load(16'h1474, 4'h2, 1'b1);
      t_load(16'h0056, 4'h0, 1'b1);
      t_refused;
      print_verdict;
   end
endmodule // test_boot_program_loader
